// >>> pkg/carrier_defines.svh
// Purpose: Offsets, field positions and reset values for the high-carrier select stage
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Definitions only
`ifndef CARRIER_DEFINES_SVH
`define CARRIER_DEFINES_SVH
`define HCS_CTRL_OFFSET    12'h000
`define HCS_SEL_MSB        3
`define HCS_SEL_LSB        0
`define HCS_SYNC_BIT       5
`define HCS_INV_BIT        6
`define HCS_PINDIS_BIT     7
`define HCS_CTRL_RESET     8'h00
`define HCS_CTRL_WMASK     8'hef
`define HCS_SEL_GROUND     4'h0
`define HCS_SEL_PIN_ONE    4'h1
`define HCS_SEL_PIN_TWO    4'h2
`define HCS_SEL_REFCLK     4'h3
`define HCS_SEL_PWM1       4'h4
`define HCS_SEL_PWM2       4'h5
`define HCS_SEL_PWM3       4'h6
`define HCS_SEL_PWM4       4'h7
`endif

// >>> pkg/carrier_pkg.sv
// Purpose: Types for the high-carrier select stage
// Assumes: Constants live in carrier_defines.svh
// Notes:   Sources travel as one packed struct
package carrier_pkg;
  typedef struct packed {
    logic pwm4;
    logic pwm3;
    logic pwm2;
    logic pwm1;
    logic ref_clock;
    logic carrier_input_pin_two;
    logic carrier_input_pin_one;
  } sources_type;
  typedef struct packed {
    logic       high_carrier_pin_disable;
    logic       high_carrier_invert;
    logic       high_carrier_edge_sync;
    logic       unused4;
    logic [3:0] high_carrier_select;
  } control_type;
  typedef enum logic [0:0] {
    HOLD_HIGH = 1'b0,
    WAIT_FALL = 1'b1
  } sync_state_type;
endpackage

// >>> verilog/high_carrier_select.sv
// Purpose: Selects, inverts and edge-syncs the high carrier of the modulator
// Assumes: All inputs synchronous to pclk; APB slave for the control register
// Notes:   Carrier is sampled on pclk, so edges are seen at system clock rate
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "carrier_defines.svh"

// Function
// - Bits 3-0 choose carrier: 0000 ground, else PWM, reference clock or pins.
// - Codes 1000 to 1111 are reserved and connect no carrier.
// - Bit 6 set inverts the selected carrier; clear passes it unchanged.
// - Bit 5 set defers high-to-low switching until the carrier's falling edge.
// - Bit 5 clear switches immediately; shortened pulses or glitches are expected.
module high_carrier_select (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire carrier_pkg::sources_type  sources,
  input  wire logic                      mod_source,
  output logic                           high_carrier,
  output logic                           use_high,
  output logic                           source_pin_enable
);

  carrier_pkg::control_type    ctrl;
  carrier_pkg::sync_state_type state;
  carrier_pkg::sync_state_type next_state;
  logic                        carrier_prev;
  logic                        selected;
  logic                        carrier_now;
  logic                        falling;
  logic                        mod_prev;

  // Bus decode; single-cycle access, unmapped addresses flag an error
  wire hit    = (paddr == `HCS_CTRL_OFFSET);
  wire access = psel & penable;
  wire wr_en  = access & pwrite & hit;
  wire [7:0] write_byte = pwdata[7:0] & `HCS_CTRL_WMASK; // Upper bus bits ignored
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata  = hit ? {24'h000000, ctrl} : 32'h00000000;

  // Control register; bit 4 is unimplemented and stays zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= carrier_pkg::control_type'(`HCS_CTRL_RESET);
    end else if (wr_en) begin
      ctrl <= carrier_pkg::control_type'(write_byte);
    end
  end

  // reserved codes fall to default and yield no carrier
  always_comb begin
    case (ctrl.high_carrier_select)
      `HCS_SEL_GROUND:  selected = 1'b0;
      `HCS_SEL_PIN_ONE: selected = sources.carrier_input_pin_one;
      `HCS_SEL_PIN_TWO: selected = sources.carrier_input_pin_two;
      `HCS_SEL_REFCLK:  selected = sources.ref_clock;
      `HCS_SEL_PWM1:    selected = sources.pwm1;
      `HCS_SEL_PWM2:    selected = sources.pwm2;
      `HCS_SEL_PWM3:    selected = sources.pwm3;
      `HCS_SEL_PWM4:    selected = sources.pwm4;
      default:          selected = 1'b0;
    endcase
  end

  assign carrier_now = selected ^ ctrl.high_carrier_invert;

  assign source_pin_enable = ~ctrl.high_carrier_pin_disable;

  // Previous output sample for falling-edge detection; watching the registered
  // output rather than the raw mux keeps the last high cycle whole under sync.
  // A select or polarity write can itself look like a fall and end a wait early.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_prev <= 1'b0;
    end else begin
      carrier_prev <= high_carrier;
    end
  end
  assign falling = carrier_prev & ~high_carrier;

  // hold high carrier until its falling edge
  // without sync, follow the modulation source directly
  always_comb begin
    next_state = state;
    case (state)
      carrier_pkg::HOLD_HIGH: begin
        if (mod_source) begin
          next_state = carrier_pkg::HOLD_HIGH;
        end else if (mod_prev && ctrl.high_carrier_edge_sync && !falling) begin
          next_state = carrier_pkg::WAIT_FALL;
        end
      end
      carrier_pkg::WAIT_FALL: begin
        if (mod_source) begin
          next_state = carrier_pkg::HOLD_HIGH;
        end else if (falling || !ctrl.high_carrier_edge_sync) begin
          next_state = carrier_pkg::HOLD_HIGH;
        end
      end
      default: next_state = carrier_pkg::HOLD_HIGH;
    endcase
  end

  // Tracks whether a deferred switch is pending; mod_prev marks a fresh fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= carrier_pkg::HOLD_HIGH;
      mod_prev <= 1'b0;
    end else begin
      state    <= next_state;
      mod_prev <= mod_source;
    end
  end

  // Mixing stage uses the high carrier while this is high
  wire pending = (state == carrier_pkg::WAIT_FALL) & ~falling;
  assign use_high = mod_source
                  | (ctrl.high_carrier_edge_sync & mod_prev & ~falling)
                  | (ctrl.high_carrier_edge_sync & pending);

  // Registered carrier output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_carrier <= 1'b0;
    end else begin
      high_carrier <= carrier_now;
    end
  end

  // output matches inverted or plain selection one cycle later
  a_polarity_path: assert property (@(posedge pclk) disable iff (!presetn)
    high_carrier == $past(carrier_now))
    else $error("High carrier does not follow polarity-selected source");

  a_reserved_codes: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.high_carrier_select[3] |-> selected == 1'b0)
    else $error("Reserved select code connected a carrier");

  a_ground_code: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.high_carrier_select == `HCS_SEL_GROUND |-> carrier_now == ctrl.high_carrier_invert)
    else $error("Ground code not giving a static carrier");

  a_nosync_switch: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.high_carrier_edge_sync |-> use_high == mod_source)
    else $error("Unsynchronised switch was delayed");

  // no switch away in the cycle the modulation source falls, unless the carrier falls too
  a_sync_defer: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.high_carrier_edge_sync && mod_prev && !mod_source && !falling |-> use_high)
    else $error("Switch to low carrier not deferred");

  a_pin_disable: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ctrl.high_carrier_pin_disable) |-> !source_pin_enable)
    else $error("Source pin still driven while disabled");

  // Steps of the deferred switch: the request, then the output fall
  sequence s_switch_request;
    ctrl.high_carrier_edge_sync && mod_prev && !mod_source && !falling;
  endsequence

  sequence s_output_fall;
    high_carrier ##1 !high_carrier;
  endsequence

  a_wait_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_switch_request |=> state == carrier_pkg::WAIT_FALL)
    else $error("Deferred switch did not enter the wait state");

  a_fall_detect: assert property (@(posedge pclk) disable iff (!presetn)
    s_output_fall |-> falling)
    else $error("Falling edge of the high carrier missed");

  a_sync_release: assert property (@(posedge pclk) disable iff (!presetn)
    state == carrier_pkg::WAIT_FALL && falling |-> use_high == mod_source)
    else $error("Wait did not end at the carrier falling edge");

  a_wait_needs_sync: assert property (@(posedge pclk) disable iff (!presetn)
    state == carrier_pkg::WAIT_FALL |-> $past(ctrl.high_carrier_edge_sync))
    else $error("Wait state held without sync enabled");

  a_mod_high: assert property (@(posedge pclk) disable iff (!presetn)
    mod_source |-> use_high)
    else $error("High modulation source did not select the high carrier");

  a_write_mask: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en |=> ctrl == carrier_pkg::control_type'($past(write_byte)))
    else $error("Control write did not land as masked");

  a_unused_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.unused4 == 1'b0)
    else $error("Unimplemented control bit set");

  a_ground_low: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl.high_carrier_select == `HCS_SEL_GROUND && !ctrl.high_carrier_invert) [*2]
    |-> high_carrier == 1'b0)
    else $error("Ground code drove the output high");

  a_reserved_output: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.high_carrier_select[3] [*2] |-> high_carrier == $past(ctrl.high_carrier_invert))
    else $error("Reserved code let a carrier reach the output");

  a_pin_level: assert property (@(posedge pclk) disable iff (!presetn)
    source_pin_enable == !ctrl.high_carrier_pin_disable)
    else $error("Source pin enable disagrees with the disable bit");

endmodule // high_carrier_select

// >>> verification/carrier_sources_model.sv
// Purpose: Stand-in for the on-chip carrier sources feeding the select stage
// Assumes: Every source is a pclk-synchronous square wave
// Notes:   Each bit toggles at its own rate, so any wrong select shows up within 128 cycles
`timescale 1ns/10ps
module carrier_sources_model (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  output carrier_pkg::sources_type      sources
);
  logic [6:0] count;
  // Free-running count; bit n toggles every 2**n cycles, pwm4 is the slowest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) count <= 7'h00;
    else count <= count + 7'h01;
  end
  assign sources = count ^ 7'h2a; // Offset so neighbouring sources start at opposite levels
endmodule // carrier_sources_model

// >>> verification/high_carrier_select_tb.sv
// Purpose: Self-checking bench for the high-carrier select stage
// Assumes: Zero-wait APB slave, carrier registered one cycle
// Notes:   Carrier checks sample at the falling edge, away from the launch edge
`timescale 1ns/10ps
`include "carrier_defines.svh"
module high_carrier_select_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic mod_source = 1'b0, pready, pslverr, high_carrier, use_high, source_pin_enable, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [6:0] prev;
  carrier_pkg::sources_type sources;
  int error_cnt = 0, comparisons = 0, n;
  always #5 pclk = ~pclk;
  carrier_sources_model src (.pclk(pclk), .presetn(presetn), .sources(sources));
  high_carrier_select uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sources(sources), .mod_source(mod_source),
    .high_carrier(high_carrier), .use_high(use_high), .source_pin_enable(source_pin_enable));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready, takes data and error at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    chk(n == 1, 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic pick(input logic [6:0] s, input logic [3:0] c);
    return (c == `HCS_SEL_GROUND || c > `HCS_SEL_PWM4) ? 1'b0 : s[c - 4'h1];
  endfunction
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset value, write mask, unmapped address
    apb(1'b0, `HCS_CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b0);
    apb(1'b1, `HCS_CTRL_OFFSET, 32'hffff_ffff);
    apb(1'b0, `HCS_CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0000_00ef);
    @(negedge pclk);
    chk(source_pin_enable, 1'b0);
    apb(1'b1, 12'h004, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    // Every select code, plain and inverted (bit 6), over 128 cycles each
    for (int k = 0; k < 32; k++) begin
      apb(1'b1, `HCS_CTRL_OFFSET, {24'h0, 1'b0, k[4], 2'h0, k[3:0]});
      @(negedge pclk);
      chk(source_pin_enable, 1'b1);
      @(negedge pclk);
      prev = sources;
      repeat (128) begin
        @(negedge pclk);
        chk(high_carrier, pick(prev, k[3:0]) ^ k[4]);
        prev = sources;
      end
    end
    // Unsynced switch follows the modulation source at once
    apb(1'b1, `HCS_CTRL_OFFSET, {28'h0, `HCS_SEL_PWM4});
    @(posedge pclk) mod_source <= 1'b1;
    @(negedge pclk);
    chk(use_high, 1'b1);
    @(posedge pclk) mod_source <= 1'b0;
    @(negedge pclk);
    chk(use_high, 1'b0);
    // Synced switch waits for the slow carrier to fall; start on a fresh rise
    apb(1'b1, `HCS_CTRL_OFFSET, {24'h0, 8'h20 | `HCS_SEL_PWM4});
    @(posedge pclk) mod_source <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (high_carrier !== 1'b0 && n < 200);
    do begin
      @(negedge pclk);
      n++;
    end while (high_carrier !== 1'b1 && n < 200);
    chk(n < 200, 1'b1);
    @(posedge pclk) mod_source <= 1'b0;
    @(negedge pclk);
    chk(use_high, 1'b1);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (use_high !== 1'b0 && n < 200);
    chk(n < 200, 1'b1);
    chk(high_carrier, 1'b0);
    // Reset in mid-run brings register and outputs back to idle
    apb(1'b1, `HCS_CTRL_OFFSET, 32'h0000_00c7);
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    @(negedge pclk);
    chk(source_pin_enable, 1'b1);
    chk(high_carrier, 1'b0);
    apb(1'b0, `HCS_CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule // high_carrier_select_tb
